// *** hdl/sar_readout.sv ***
// Digital control and serial readout of a 12-bit successive-approximation converter.
// Notes on behaviour
// - After conversion end, output changes only on shift-clock falling edges.
// - Select high leaves output undriven.
// - Select falling edge starts a conversion.
// - Power-down low stops conversions, shutdown.
// - Power-down high or open means operating.
// - High enables internal reference, open disables.
// - Result: high bit, then 12 bits MSB first.
// - Select falling edge puts track/hold in hold.
// - Conversion end returns track/hold to track.
// - Full conversion cycle within 9us.
// - Select fall drives output low while converting.
// - Conversion end drives output high.
// - First falling edge after end gives MSB.
// - Extra shift edges give zeros, harmless.
module sar_readout
  import sar_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_select_n,
  input wire logic i_shift_clk,
  input wire logic i_pd_high,
  input wire logic i_pd_low,
  input wire logic i_cmp_high,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_track,
  output logic o_shutdown,
  output logic o_int_ref_en,
  output logic o_trial_valid,
  output logic [RESULT_BITS-1:0] o_trial_code,
  output logic o_busy
);

  // ---------------------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic sel_s;
  logic sclk_s;
  logic pd_high_s;
  logic pd_low_s;
  logic cmp_s;

  sar_sync u_sync_sel (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_level(~i_select_n),
    .o_level(sel_s));
  sar_sync u_sync_sclk (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_level(i_shift_clk),
    .o_level(sclk_s));
  sar_sync u_sync_pdh (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_level(i_pd_high),
    .o_level(pd_high_s));
  sar_sync u_sync_pdl (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_level(i_pd_low),
    .o_level(pd_low_s));
  sar_sync u_sync_cmp (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_level(i_cmp_high),
    .o_level(cmp_s));

  // The select synchroniser carries the inverted pin, so a reset value of zero
  // reads as select high and the output starts undriven.
  logic sel_active;
  assign sel_active = sel_s;

  // ---------------------------------------------------------------------------
  // Edge detection and power-down decode
  // ---------------------------------------------------------------------------
  logic sel_prev;
  logic sclk_prev;
  logic sel_fall;
  logic sclk_fall;
  sar_pd_level_t pd_level;

  assign sel_fall = sel_active & ~sel_prev;
  assign sclk_fall = sclk_prev & ~sclk_s;

  always_comb begin
    if (pd_low_s) begin
      pd_level = SAR_PD_LOW;
    end else if (pd_high_s) begin
      pd_level = SAR_PD_HIGH;
    end else begin
      pd_level = SAR_PD_OPEN;
    end
  end

  // ---------------------------------------------------------------------------
  // Conversion and shift state
  // ---------------------------------------------------------------------------
  sar_state_t state;
  sar_state_t next_state;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic [CONV_CNT_W-1:0] next_conv_cnt;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [RESULT_BITS-1:0] approx;
  logic [RESULT_BITS-1:0] next_approx;
  logic [RESULT_BITS:0] shreg;
  logic [RESULT_BITS:0] next_shreg;
  logic dout;
  logic next_dout;
  logic dout_oe;
  logic next_dout_oe;
  logic track;
  logic next_track;
  logic shutdown;
  logic next_shutdown;
  logic int_ref;
  logic next_int_ref;
  logic [CONV_CNT_W-1:0] trial_step;

  // Successive bits are trialled over evenly spaced slots of the conversion
  // time, so the internal timer alone paces the conversion.
  assign trial_step = CONV_CNT_W'(CONV_CYCLES / RESULT_BITS);

  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_bit_idx = bit_idx;
    next_approx = approx;
    next_shreg = shreg;
    next_dout = dout;
    next_dout_oe = sel_active;
    next_track = track;
    next_shutdown = (pd_level == SAR_PD_LOW);
    next_int_ref = (pd_level == SAR_PD_HIGH);
    if (!sel_active) begin
      next_dout = 1'b0;
    end
    case (state)
      SAR_IDLE: begin
        next_track = 1'b1;
        if (sel_fall && pd_level != SAR_PD_LOW) begin
          next_state = SAR_CONVERT;
          next_track = 1'b0;
          next_dout = 1'b0;
          next_conv_cnt = '0;
          next_bit_idx = 4'(RESULT_BITS - 1);
          next_approx = {1'b1, {(RESULT_BITS-1){1'b0}}};
        end
      end
      SAR_CONVERT: begin
        next_conv_cnt = conv_cnt + 1'b1;
        if (conv_cnt != '0 && conv_cnt == trial_step * CONV_CNT_W'(RESULT_BITS - bit_idx)
            && bit_idx != 4'hf) begin
          next_approx[bit_idx] = cmp_s;
          if (bit_idx != 4'h0) begin
            next_approx[bit_idx - 4'h1] = 1'b1;
          end
          next_bit_idx = bit_idx - 4'h1;
        end
        if (!sel_active || pd_level == SAR_PD_LOW) begin
          next_state = SAR_IDLE;
          next_track = 1'b1;
        end else if (conv_cnt == CONV_LAST) begin
          next_state = SAR_SHIFT;
          next_track = 1'b1;
          next_dout = 1'b1;
          next_shreg = {approx, 1'b0};
        end
      end
      SAR_SHIFT: begin
        if (!sel_active) begin
          next_state = SAR_IDLE;
        end else if (sclk_fall) begin
          next_dout = shreg[RESULT_BITS];
          next_shreg = {shreg[RESULT_BITS-1:0], 1'b0};
        end
      end
      default: begin
        next_state = SAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SAR_IDLE;
      conv_cnt <= '0;
      bit_idx <= 4'h0;
      approx <= RESULT_RESET;
      shreg <= '0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      track <= 1'b1;
      shutdown <= 1'b0;
      int_ref <= 1'b0;
      sel_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      bit_idx <= next_bit_idx;
      approx <= next_approx;
      shreg <= next_shreg;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      track <= next_track;
      shutdown <= next_shutdown;
      int_ref <= next_int_ref;
      sel_prev <= sel_active;
      sclk_prev <= sclk_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_dout = dout & dout_oe;
  assign o_dout_oe = dout_oe;
  assign o_track = track;
  assign o_shutdown = shutdown;
  assign o_int_ref_en = int_ref;
  assign o_trial_code = approx;
  assign o_trial_valid = (state == SAR_CONVERT);
  assign o_busy = (state == SAR_CONVERT);

endmodule : sar_readout

// *** common/sar_pkg.sv ***
// Package of constants and types for the serial SAR converter readout block.
package sar_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_NS = 7500;
  localparam int CYCLE_MAX_NS = 9000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int CYCLE_MAX_CYCLES = (CYCLE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ---------------------------------------------------------------------------
  // Result format
  // ---------------------------------------------------------------------------
  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS = RESULT_BITS + 1;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;

  // ---------------------------------------------------------------------------
  // Power-down select levels and controller states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SAR_PD_LOW,
    SAR_PD_HIGH,
    SAR_PD_OPEN
  } sar_pd_level_t;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_CONVERT,
    SAR_SHIFT
  } sar_state_t;

endpackage : sar_pkg

// *** hdl/sar_sync.sv ***
// Two flip-flop synchroniser for one input level.
module sar_sync
  import sar_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_level
);

  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb begin
    next_stage1 = i_level;
    next_stage2 = stage1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign o_level = stage2;

endmodule : sar_sync

// *** tb/sar_readout_asserts.sv ***
// Concurrent checks on the ports of the serial converter readout block.
module sar_readout_asserts
  import sar_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_select_n,
  input wire logic i_shift_clk,
  input wire logic i_pd_high,
  input wire logic i_pd_low,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_track,
  input wire logic o_shutdown,
  input wire logic o_int_ref_en,
  input wire logic o_trial_valid,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busy_cnt;
  logic [7:0] low_cnt;
  logic [7:0] next_busy_cnt;
  logic [7:0] next_low_cnt;
  // The low counter saturates so a long idle never wraps into the legal window.
  always_comb begin
    next_busy_cnt = o_busy ? busy_cnt + 8'h01 : 8'h00;
    next_low_cnt = i_shift_clk ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_cnt <= 8'h00;
      low_cnt <= 8'h00;
    end else begin
      busy_cnt <= next_busy_cnt;
      low_cnt <= next_low_cnt;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_idle_no_drive: assert property (i_select_n [*4] |-> !o_dout_oe)
    else $error("output driven while deselected");
  a_start_hold: assert property (
    $fell(i_select_n) && !i_pd_low |-> ##3 (o_busy && o_dout_oe && !o_dout && !o_track))
    else $error("conversion did not start on select fall");
  a_conv_time: assert property (o_busy |-> busy_cnt < CONV_CYCLES)
    else $error("conversion runs too long");
  a_eoc_high: assert property (
    $fell(o_busy) && !i_select_n && !o_shutdown
      |-> busy_cnt == CONV_CYCLES && o_dout && o_track && o_dout_oe)
    else $error("end of conversion not flagged");
  a_shutdown_idle: assert property (o_shutdown |-> !o_busy)
    else $error("converting while shut down");
  a_pd_low: assert property (i_pd_low [*6] |-> o_shutdown && !o_int_ref_en)
    else $error("low power pin not obeyed");
  a_pd_high: assert property (i_pd_high [*6] |-> o_int_ref_en && !o_shutdown)
    else $error("high power pin not obeyed");
  a_pd_open: assert property (
    (!i_pd_low && !i_pd_high) [*6] |-> !o_shutdown && !o_int_ref_en)
    else $error("open power pin not obeyed");
  a_dout_on_fall: assert property (
    o_dout_oe && $past(o_dout_oe) && !$past(o_busy) && $changed(o_dout)
      |-> !i_shift_clk && low_cnt >= 8'h01 && low_cnt <= 8'h04)
    else $error("data changed away from a shift fall");
  a_trial_hold: assert property (o_trial_valid |-> o_busy && !o_track)
    else $error("trials run outside a held conversion");
endmodule : sar_readout_asserts

bind sar_readout sar_readout_asserts u_chk (.i_mclk, .i_reset_n, .i_select_n, .i_shift_clk,
  .i_pd_high, .i_pd_low, .o_dout, .o_dout_oe, .o_track, .o_shutdown, .o_int_ref_en,
  .o_trial_valid, .o_busy);

// *** tb/sar_ctl_model.sv ***
// Serial master model that starts conversions and shifts results out.
module sar_ctl_model (
  input wire logic i_mclk,
  input wire logic i_dout,
  input wire logic i_dout_oe,
  output logic o_select_n,
  output logic o_shift_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  logic line;
  // An undriven line toggles so a stale level can never pass for data.
  assign line = i_dout_oe ? i_dout : ~last;
  always @(posedge i_mclk) last <= line;
  initial begin
    o_select_n = 1'b1;
    o_shift_clk = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask : step
  task automatic read_frame(input int nclk, input int abort_at, output logic [15:0] w,
                            output logic ok);
    w = 16'h0000;
    ok = 1'b0;
    o_select_n = 1'b0;
    if (abort_at > 0) begin
      step(abort_at);
      o_select_n = 1'b1;
      step(15);
      return;
    end
    step(4);
    for (int t = 0; t < 90 && line !== 1'b1; t++) step(1);
    ok = (line === 1'b1);
    repeat (nclk) begin
      o_shift_clk = 1'b1;
      w = {w[14:0], line};
      step(4);
      o_shift_clk = 1'b0;
      step(4);
    end
    o_select_n = 1'b1;
    step(15);
  endtask : read_frame
endmodule : sar_ctl_model

// *** tb/sar_readout_tb.sv ***
// Self-checking bench for the serial converter readout block.
module sar_readout_tb
  import sar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_pd_high = 1'b1;
  logic i_pd_low = 1'b0;
  logic [RESULT_BITS-1:0] analog_input = 12'h000;
  logic [RESULT_BITS-1:0] trial;
  logic select_n, shift_clk, dout, dout_oe, track, shutdown, int_ref, busy, ok;
  logic [15:0] w;
  int err_count = 0;
  int comparisons = 0;
  int n;
  always #50 i_mclk = ~i_mclk;
  sar_readout DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_select_n(select_n),
    .i_shift_clk(shift_clk), .i_pd_high(i_pd_high), .i_pd_low(i_pd_low),
    .i_cmp_high(analog_input >= trial), .o_dout(dout), .o_dout_oe(dout_oe), .o_track(track),
    .o_shutdown(shutdown), .o_int_ref_en(int_ref), .o_trial_valid(),
    .o_trial_code(trial), .o_busy(busy));
  sar_ctl_model ctl (.i_mclk(i_mclk), .i_dout(dout), .i_dout_oe(dout_oe),
    .o_select_n(select_n), .o_shift_clk(shift_clk));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  function automatic logic [15:0] frame_of(input logic [RESULT_BITS-1:0] v, input int k);
    return {1'b1, v, 3'b000} >> (16 - k);
  endfunction : frame_of
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    n = $urandom(32'hfe955656);
    ctl.step(10);
    check("reset_outs", 16'h0004, {13'h0, track, dout_oe, busy});
    i_reset_n = 1'b1;
    ctl.step(8);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      i_pd_low = (m == 0);
      i_pd_high = (m == 1);
      ctl.step(8);
      check("pd_outs", 16'(m == 0 ? 2 : m == 1 ? 1 : 0), {14'h0, shutdown, int_ref});
      analog_input = 12'($urandom);
      ctl.read_frame(13, 0, w, ok);
      check("conv_accept", 16'(m != 0), {15'h0, ok});
      if (m != 0) check("frame", frame_of(analog_input, 13), w);
    end
    // Shutdown in mid-conversion must abandon the conversion with select still low.
    fork
      ctl.read_frame(13, 0, w, ok);
      begin
        ctl.step(30);
        i_pd_low = 1'b1;
      end
    join
    check("pd_abort", 16'h0002, {13'h0, ok, shutdown, busy});
    i_pd_low = 1'b0;
    ctl.step(8);
    $display("test power modes done");
    for (int i = 0; i < 10; i++) begin
      analog_input = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      n = 13 + $urandom_range(3);
      ctl.read_frame(n, 0, w, ok);
      check("eoc_seen", 16'h0001, {15'h0, ok});
      check("frame", frame_of(analog_input, n), w);
      if (ok !== 1'b1) end_of_test();
    end
    $display("test random frames done");
    ctl.read_frame(0, 20, w, ok);
    check("abort_idle", 16'h0004, {13'h0, track, dout_oe, busy});
    analog_input = 12'ha5c;
    ctl.read_frame(16, 0, w, ok);
    check("after_abort_eoc", 16'h0001, {15'h0, ok});
    check("after_abort", frame_of(analog_input, 16), w);
    $display("test abort done");
    end_of_test();
  end
endmodule : sar_readout_tb
